/* src/tcu_pkg.sv */
// Constants shared by the timer capture one-shot unit
package tcu_pkg;
  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    TCU_MODE_STOP,
    TCU_MODE_FREE,
    TCU_MODE_TWOCAP,
    TCU_MODE_RESTART,
    TCU_MODE_EVENT,
    TCU_MODE_OS_EXT
  } tcu_mode_t;

  // ----------------------------------------
  // Field positions and encodings
  // ----------------------------------------
  localparam int TCU_ES_LO_BIT = 4;
  localparam int TCU_ES_HI_BIT = 5;
  localparam int TCU_OC_OE_BIT = 0;
  localparam int TCU_OC_TOG_BIT = 1;
  localparam int TCU_OC_OSP_BIT = 6;
  localparam logic [1:0] TCU_EDGE_FALL = 2'h0;
  localparam logic [1:0] TCU_EDGE_RISE = 2'h1;
  localparam logic [1:0] TCU_EDGE_BOTH = 2'h3;
  localparam logic [2:0] TCU_PS_DIV2 = 3'h0;
  localparam logic [2:0] TCU_PS_DIV4 = 3'h1;
  localparam logic [2:0] TCU_PS_DIV16 = 3'h2;
  localparam logic [2:0] TCU_PS_EDGE = 3'h3;
  localparam logic [2:0] TCU_PS_DIV32 = 3'h4;
  localparam logic [2:0] TCU_PS_DIV128 = 3'h5;
  localparam logic [2:0] TCU_PS_DIV256 = 3'h6;
  localparam logic [15:0] TCU_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TCU_CNT_ZERO = 16'h0000;
  localparam int TCU_DIV_W = 8;
endpackage : tcu_pkg

/* src/tcu_prescaler.sv */
// Divider giving count clock enables, held at zero while the timer is stopped
module tcu_prescaler (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  output logic half_en_o,
  output logic cnt_en_o
);
  logic [tcu_pkg::TCU_DIV_W-1:0] div_q;
  logic [tcu_pkg::TCU_DIV_W-1:0] mask;

  // ----------------------------------------
  // Divide-ratio decode
  // ----------------------------------------
  function automatic logic [tcu_pkg::TCU_DIV_W-1:0] div_mask(input logic [2:0] s);
    case (s)
      tcu_pkg::TCU_PS_DIV2: div_mask = 8'h01;
      tcu_pkg::TCU_PS_DIV4: div_mask = 8'h03;
      tcu_pkg::TCU_PS_DIV16: div_mask = 8'h0F;
      tcu_pkg::TCU_PS_DIV32: div_mask = 8'h1F;
      tcu_pkg::TCU_PS_DIV128: div_mask = 8'h7F;
      default: div_mask = 8'hFF;
    endcase
  endfunction : div_mask

  assign mask = div_mask(sel_i);

  // Divider restarts with the timer, so first tick may lag
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= 8'h00;
    end else if (!run_i) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign half_en_o = run_i && div_q[0];
  assign cnt_en_o = run_i && ((div_q & mask) == mask);
endmodule : tcu_prescaler

/* src/tcu_edge_filter.sv */
// Two-sample noise filter and edge detector on a sampling enable
module tcu_edge_filter (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic run_i,
  input wire logic smp_en_i,
  input wire logic pin_i,
  output logic rise_o,
  output logic fall_o
);
  logic s1_q;
  logic lvl_q;

  // Level accepted only after two equal samples
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 1'b0;
      lvl_q <= 1'b0;
    end else if (smp_en_i) begin
      s1_q <= pin_i;
      if (s1_q == pin_i) begin
        lvl_q <= pin_i;
      end
    end
  end

  assign rise_o = run_i && smp_en_i && (s1_q == pin_i) && pin_i && !lvl_q;
  assign fall_o = run_i && smp_en_i && (s1_q == pin_i) && !pin_i && lvl_q;
endmodule : tcu_edge_filter

/* src/tcu_core.sv */
// Timer capture one-shot unit top level
// Operation
// [R1] Two-capture: edge captures into B, irq
// [R2] Two-capture: opposite edge captures into A
// [R3] Both-edges select blocks A capture
// [R4] Capture input filtered on count clock; the code filters it at half clock when the external clock is selected
// [R5] Restart: capture B then clear counter
// [R6] Restart: opposite edge captures into A
// [R7] Event mode counts valid input edges
// [R8] Event mode clears on A match, irq
// [R9] Event input filtered at half clock
// [R10] Enable plus toggle inverts output on match
// [R11] Soft trigger clears and starts counter
// [R12] One-shot active between B and A
// [R13] Counter keeps running until mode stop
// [R14] Software waits out a running pulse
// [R15] External edge starts one-shot pulse
// [R16] External retrigger restarts the pulse
// [R17] First match may lag one count clock
// [R18] Three-bit prescaler selects count clock
// [R19] Free-running wrap sets wrap flag
module tcu_core (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [2:0] timer_mode_ctrl_i,
  input wire logic [2:0] prescale_sel_i,
  input wire logic [7:0] prescale_mode_a_i,
  input wire logic [7:0] output_ctrl_i,
  input wire logic soft_pulse_trigger_i,
  input wire logic [15:0] cmp_a_i,
  input wire logic cmp_a_we_i,
  input wire logic [15:0] cmp_b_i,
  input wire logic cmp_b_we_i,
  input wire logic wrap_clr_i,
  input wire logic trigger_input_a_i,
  output logic [15:0] count_register_o,
  output logic [15:0] capcomp_reg_a_o,
  output logic [15:0] capcomp_reg_b_o,
  output logic match_irq_a_o,
  output logic capture_irq_b_o,
  output logic pulse_out_pin_o,
  output logic wrap_flag_o,
  output logic pulse_busy_o
);
  tcu_pkg::tcu_mode_t mode;
  logic run;
  logic half_en;
  logic cnt_en;
  logic ext_clk;
  logic tick;
  logic [1:0] es;
  logic smp_en;
  logic rise;
  logic fall;
  logic edge_valid;
  logic edge_rev;
  logic match_a;
  logic match_b;
  logic [15:0] cnt_q;
  logic [15:0] cra_q;
  logic [15:0] crb_q;
  logic os_start;
  logic os_act_q;
  logic out_q;
  logic wrap_q;
  logic irq_a_q;
  logic irq_b_q;

  // ----------------------------------------
  // Mode and edge decode
  // ----------------------------------------
  assign mode = tcu_pkg::tcu_mode_t'(timer_mode_ctrl_i);
  assign run = (mode != tcu_pkg::TCU_MODE_STOP) && (timer_mode_ctrl_i <= 3'h5); // R13
  assign es = {prescale_mode_a_i[tcu_pkg::TCU_ES_HI_BIT],
               prescale_mode_a_i[tcu_pkg::TCU_ES_LO_BIT]};

  function automatic logic edge_hit(input logic [1:0] sel, input logic r, input logic f);
    case (sel)
      tcu_pkg::TCU_EDGE_FALL: edge_hit = f;
      tcu_pkg::TCU_EDGE_RISE: edge_hit = r;
      tcu_pkg::TCU_EDGE_BOTH: edge_hit = r | f;
      default: edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  // ----------------------------------------
  // Count clock and input filter
  // ----------------------------------------
  tcu_prescaler u_pre (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(run),
    .sel_i(prescale_sel_i),
    .half_en_o(half_en),
    .cnt_en_o(cnt_en)
  );

  assign ext_clk = (prescale_sel_i == tcu_pkg::TCU_PS_EDGE);
  // Event mode and external clock sample at half rate
  assign smp_en = (mode == tcu_pkg::TCU_MODE_EVENT || ext_clk) ? half_en : cnt_en; // R4 R9

  tcu_edge_filter u_flt (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .run_i(run),
    .smp_en_i(smp_en),
    .pin_i(trigger_input_a_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  assign edge_valid = edge_hit(es, rise, fall);
  // Opposite edge only exists for a single-edge selection
  assign edge_rev = (es == tcu_pkg::TCU_EDGE_RISE) ? fall :
                    (es == tcu_pkg::TCU_EDGE_FALL) ? rise : 1'b0; // R3
  assign tick = (mode == tcu_pkg::TCU_MODE_EVENT || ext_clk) ? edge_valid : cnt_en; // R7 R18

  assign match_a = run && (cnt_q == cra_q);
  assign match_b = run && (cnt_q == crb_q);
  assign os_start = run && (soft_pulse_trigger_i ||
                    (mode == tcu_pkg::TCU_MODE_OS_EXT && edge_valid)); // R11 R15

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  // Counter starts at zero off the divider phase, first match may lag
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin // R17
    if (!rstn_i) begin
      cnt_q <= tcu_pkg::TCU_CNT_ZERO;
    end else if (!run) begin
      cnt_q <= tcu_pkg::TCU_CNT_ZERO; // R13
    end else if (os_start) begin
      cnt_q <= tcu_pkg::TCU_CNT_ZERO; // R11 R16
    end else if (mode == tcu_pkg::TCU_MODE_RESTART && edge_valid) begin
      cnt_q <= tcu_pkg::TCU_CNT_ZERO; // R5
    end else if (tick) begin
      if (mode == tcu_pkg::TCU_MODE_EVENT && match_a) begin
        cnt_q <= tcu_pkg::TCU_CNT_ZERO; // R8
      end else begin
        cnt_q <= cnt_q + 16'h0001; // R7 R19
      end
    end
  end

  // ----------------------------------------
  // Capture and compare registers
  // ----------------------------------------
  // Capture has priority over a software write in the same cycle
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      crb_q <= tcu_pkg::TCU_CNT_ZERO;
    end else if ((mode == tcu_pkg::TCU_MODE_TWOCAP || mode == tcu_pkg::TCU_MODE_RESTART)
                 && edge_valid) begin
      crb_q <= cnt_q; // R1 R5
    end else if (cmp_b_we_i) begin
      crb_q <= cmp_b_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cra_q <= tcu_pkg::TCU_CNT_MAX;
    end else if ((mode == tcu_pkg::TCU_MODE_TWOCAP || mode == tcu_pkg::TCU_MODE_RESTART)
                 && edge_rev) begin
      cra_q <= cnt_q; // R2 R6
    end else if (cmp_a_we_i) begin
      cra_q <= cmp_a_i;
    end
  end

  // ----------------------------------------
  // Flags and interrupts
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_a_q <= 1'b0;
      irq_b_q <= 1'b0;
    end else begin
      irq_a_q <= tick && mode == tcu_pkg::TCU_MODE_EVENT && match_a; // R8
      irq_b_q <= (mode == tcu_pkg::TCU_MODE_TWOCAP || mode == tcu_pkg::TCU_MODE_RESTART)
                 && edge_valid; // R1
    end
  end

  // Set beats clear so a wrap is never lost
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wrap_q <= 1'b0;
    end else if (tick && cnt_q == tcu_pkg::TCU_CNT_MAX && !os_start) begin
      wrap_q <= 1'b1; // R19
    end else if (wrap_clr_i) begin
      wrap_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pulse output
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      os_act_q <= 1'b0;
      out_q <= 1'b0;
    end else if (!run || !output_ctrl_i[tcu_pkg::TCU_OC_OE_BIT]) begin
      os_act_q <= 1'b0;
      out_q <= 1'b0;
    end else if (os_start) begin
      os_act_q <= 1'b1; // R16
      out_q <= 1'b0;
    end else if (os_act_q) begin
      if ((crb_q < cra_q) ? match_b : match_a) begin
        out_q <= 1'b1; // R12
      end else if ((crb_q < cra_q) ? match_a : match_b) begin
        out_q <= 1'b0; // R12
        os_act_q <= 1'b0;
      end
    end else if (output_ctrl_i[tcu_pkg::TCU_OC_TOG_BIT] && tick && (match_a || match_b)) begin
      out_q <= !out_q; // R10
    end
  end

  assign count_register_o = cnt_q;
  assign capcomp_reg_a_o = cra_q;
  assign capcomp_reg_b_o = crb_q;
  assign match_irq_a_o = irq_a_q;
  assign capture_irq_b_o = irq_b_q;
  assign pulse_out_pin_o = out_q;
  assign wrap_flag_o = wrap_q;
  assign pulse_busy_o = os_act_q; // R14

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cap_b;
    (mode == tcu_pkg::TCU_MODE_TWOCAP) && edge_valid;
  endsequence

  a_cap_b_value: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R1
    s_cap_b |=> (crb_q == $past(cnt_q)) && capture_irq_b_o)
    else $error("capture B missed");
  a_cap_a_both: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R3
    (es == tcu_pkg::TCU_EDGE_BOTH && !cmp_a_we_i) |=> $stable(cra_q))
    else $error("capture A with both edges");
  a_restart_clr: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R5
    (mode == tcu_pkg::TCU_MODE_RESTART && edge_valid && !os_start) |=> cnt_q == 16'h0000)
    else $error("restart did not clear");
  a_event_match: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R8
    (mode == tcu_pkg::TCU_MODE_EVENT && tick && match_a && !os_start)
    |=> cnt_q == 16'h0000 && match_irq_a_o)
    else $error("event match no clear");
  a_soft_start: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R11
    (soft_pulse_trigger_i && run) |=> cnt_q == 16'h0000)
    else $error("soft trigger no clear");
  a_stop_zero: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R13
    !run |=> cnt_q == 16'h0000 && !pulse_out_pin_o)
    else $error("stopped counter moved");
  a_retrig_out: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
    (os_start && output_ctrl_i[tcu_pkg::TCU_OC_OE_BIT]) |=> pulse_busy_o && !pulse_out_pin_o)
    else $error("retrigger not restarted");
  a_wrap_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R19
    (tick && cnt_q == 16'hFFFF && !os_start && run) |=> wrap_flag_o ##0 cnt_q == 16'h0000)
    else $error("wrap flag missing");
endmodule : tcu_core

/* testbench/tcu_pulse_src.sv */
// Partner model: external pulse source on input A
module tcu_pulse_src (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic lvl_i,
  input wire logic glitch_i,
  output logic pin_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Pin driver
  // ----------------------------------------
  // Glitch only on bench command, one clock wide, so the filter must reject it
  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_o <= 1'b0;
    end else begin
      pin_o <= lvl_i ^ glitch_i;
    end
  end
endmodule : tcu_pulse_src

/* testbench/tcu_core_bench.sv */
// Directed bench for the timer capture one-shot unit
module tcu_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] ps = 3'h0;
  logic [7:0] pma = 8'h00;
  logic [7:0] oc = 8'h00;
  logic sw = 1'b0;
  logic [15:0] ca = 16'h0000;
  logic [15:0] cb = 16'h0000;
  logic cawe = 1'b0;
  logic cbwe = 1'b0;
  logic lvl = 1'b0;
  logic glitch = 1'b0;
  logic wclr = 1'b0;
  logic pin;
  logic [15:0] cnt, ra, rb, sav;
  logic mirq, cirq, pout, wrap, busy;
  int num_errors = 0;
  int samples_checked = 0;

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  tcu_pulse_src src_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .lvl_i(lvl),
    .glitch_i(glitch), .pin_o(pin));

  tcu_core dut_u (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .timer_mode_ctrl_i(mode),
    .prescale_sel_i(ps), .prescale_mode_a_i(pma), .output_ctrl_i(oc),
    .soft_pulse_trigger_i(sw), .cmp_a_i(ca), .cmp_a_we_i(cawe), .cmp_b_i(cb),
    .cmp_b_we_i(cbwe), .wrap_clr_i(wclr), .trigger_input_a_i(pin),
    .count_register_o(cnt), .capcomp_reg_a_o(ra), .capcomp_reg_b_o(rb),
    .match_irq_a_o(mirq), .capture_irq_b_o(cirq), .pulse_out_pin_o(pout),
    .wrap_flag_o(wrap), .pulse_busy_o(busy));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic [2:0] m, input logic [7:0] e, input logic [7:0] o);
    @(posedge ref_clk_i);
    mode <= m;
    pma <= e;
    oc <= o;
    tick(2);
  endtask : cfg

  task automatic setcmp(input logic [15:0] a, input logic [15:0] b);
    @(posedge ref_clk_i);
    ca <= a;
    cb <= b;
    cawe <= 1'b1;
    cbwe <= 1'b1;
    @(posedge ref_clk_i);
    cawe <= 1'b0;
    cbwe <= 1'b0;
  endtask : setcmp

  task automatic drive(input logic v);
    @(posedge ref_clk_i);
    lvl <= v;
  endtask : drive

  // Bounded wait; a hang counts as a failure and closes the run
  task automatic wait_on(input int w);
    for (int i = 0; i < 600; i++) begin
      tick(1);
      if ((w == 0 && cirq === 1'b1) || (w == 1 && mirq === 1'b1) ||
          (w == 2 && pout === 1'b1) || (w == 3 && pout === 1'b0) ||
          (w == 4 && ra !== sav)) return;
    end
    num_errors++;
    results();
  endtask : wait_on

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  task automatic results();
    $display("compares=%0d mismatches=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    tick(10);
    rstn_i <= 1'b1;
    tick(1);
    chk(cnt, 16'h0000);
    chk(ra, 16'hFFFF);
    chk(rb, 16'h0000);
    chk({11'h000, mirq, cirq, pout, wrap, busy}, 16'h0000);
    @(posedge ref_clk_i);
    wclr <= 1'b1;
    @(posedge ref_clk_i);
    wclr <= 1'b0;
    tick(1);
    chk({15'h0, wrap}, 16'h0000);
    done("reset");
    cfg(3'h2, 8'h10, 8'h00);
    tick(20);
    drive(1'b1);
    wait_on(0);
    chk(ra, 16'hFFFF);
    sav = ra;
    drive(1'b0);
    wait_on(4);
    chk({15'h0, ra > rb}, 16'h0001);
    sav = rb;
    @(posedge ref_clk_i);
    glitch <= 1'b1;
    @(posedge ref_clk_i);
    glitch <= 1'b0;
    tick(20);
    chk(rb, sav);
    done("two_capture");
    cfg(3'h0, 8'h30, 8'h00);
    cfg(3'h2, 8'h30, 8'h00);
    sav = ra;
    drive(1'b1);
    wait_on(0);
    drive(1'b0);
    wait_on(0);
    chk(ra, sav);
    done("both_edges");
    cfg(3'h0, 8'h10, 8'h00);
    cfg(3'h3, 8'h10, 8'h00);
    tick(40);
    drive(1'b1);
    wait_on(0);
    chk({15'h0, cnt < rb}, 16'h0001);
    sav = ra;
    drive(1'b0);
    wait_on(4);
    chk({15'h0, ra < 16'h0008}, 16'h0001);
    done("restart");
    cfg(3'h0, 8'h30, 8'h00);
    cfg(3'h4, 8'h30, 8'h00);
    sav = cnt;
    setcmp(sav + 16'h0002, 16'h0000);
    drive(1'b1);
    tick(10);
    drive(1'b0);
    tick(10);
    chk(cnt, sav + 16'h0002);
    drive(1'b1);
    wait_on(1);
    chk(cnt, 16'h0000);
    done("event");
    cfg(3'h0, 8'h10, 8'h00);
    setcmp(16'h0040, 16'h0008);
    cfg(3'h1, 8'h10, 8'h01);
    chk({15'h0, busy}, 16'h0000);
    // Trigger only while idle, as software must
    @(posedge ref_clk_i);
    sw <= 1'b1;
    @(posedge ref_clk_i);
    sw <= 1'b0;
    wait_on(2);
    chk({15'h0, cnt >= 16'h0008 && cnt <= 16'h000A}, 16'h0001);
    chk({15'h0, busy}, 16'h0001);
    wait_on(3);
    chk({15'h0, busy}, 16'h0000);
    chk({15'h0, cnt >= 16'h0040 && cnt <= 16'h0042}, 16'h0001);
    tick(20);
    chk({15'h0, cnt > 16'h0042}, 16'h0001);
    cfg(3'h0, 8'h10, 8'h00);
    sav = cnt;
    tick(10);
    chk(cnt, sav);
    done("soft_one_shot");
    drive(1'b0);
    cfg(3'h5, 8'h10, 8'h01);
    drive(1'b1);
    wait_on(2);
    drive(1'b0);
    tick(10);
    drive(1'b1);
    tick(20);
    chk({15'h0, cnt < 16'h0010}, 16'h0001);
    wait_on(2);
    wait_on(3);
    chk({15'h0, cnt >= 16'h0040 && cnt <= 16'h0042}, 16'h0001);
    done("ext_one_shot");
    cfg(3'h0, 8'h10, 8'h00);
    setcmp(16'h0010, 16'h0030);
    cfg(3'h1, 8'h10, 8'h03);
    wait_on(2);
    chk({15'h0, cnt >= 16'h0010 && cnt <= 16'h0012}, 16'h0001);
    wait_on(3);
    chk({15'h0, cnt >= 16'h0030 && cnt <= 16'h0032}, 16'h0001);
    // Next natural match is a full wrap away, so restart from zero instead
    cfg(3'h0, 8'h10, 8'h00);
    cfg(3'h1, 8'h10, 8'h03);
    wait_on(2);
    chk({15'h0, cnt >= 16'h0010 && cnt <= 16'h0012}, 16'h0001);
    done("square");
    cfg(3'h0, 8'h10, 8'h00);
    @(posedge ref_clk_i);
    ps <= 3'h1;
    cfg(3'h1, 8'h10, 8'h00);
    sav = cnt;
    tick(40);
    chk(cnt, sav + 16'h000A);
    cfg(3'h0, 8'h10, 8'h00);
    @(posedge ref_clk_i);
    ps <= 3'h3;
    cfg(3'h1, 8'h10, 8'h00);
    drive(1'b0);
    tick(10);
    drive(1'b1);
    tick(10);
    drive(1'b0);
    tick(10);
    drive(1'b1);
    tick(10);
    chk(cnt, 16'h0002);
    done("prescale");
    results();
  end
endmodule : tcu_core_bench
